// ### shared/ppr_cfg.svh
// Register indices, field positions, masks and bus codes of the pin router
`ifndef PPR_CFG_SVH
`define PPR_CFG_SVH

`define PPR_ADDR_W         4
`define PPR_NUM_REGS       4
`define PPR_IDX_LOGIC_EV   2'h0
`define PPR_IDX_COMM       2'h1
`define PPR_IDX_TIMER_A    2'h2
`define PPR_IDX_TIMER_B    2'h3
`define PPR_MASK_LOGIC_EV  8'h37
`define PPR_MASK_COMM      8'h15
`define PPR_MASK_TIMER_A   8'h3f
`define PPR_MASK_TIMER_B   8'h01
`define PPR_RST_ROUTE      8'h00
`define PPR_B_LOGIC_TABLE_ZERO_ALT_PIN         4
`define PPR_B_LOGIC_TABLE_ONE_ALT_PIN         5
`define PPR_B_EVENT_OUT_ZERO_ENABLE       0
`define PPR_B_EVENT_OUT_TWO_ENABLE       2
`define PPR_B_TWO_WIRE     4
`define PPR_B_SERIAL_PER   2
`define PPR_B_ASYNC_SER    0
`define PPR_B_WAVE_SPLIT   3
`define PPR_B_TIMER_B      0
`define PPR_RESP_OKAY      2'h0
`define PPR_RESP_SLVERR    2'h2

`endif

// ### shared/ppr_pkg.sv
// Types shared by the pin router modules
package ppr_pkg;

   // Route registers, one byte each
   typedef struct packed {
      logic [7:0] timer_b_pin_route;
      logic [7:0] timer_a_pin_route;
      logic [7:0] comm_pin_route;
      logic [7:0] logic_event_route;
   } ppr_regs_t;

   // Register write from the bus slave
   typedef struct packed {
      logic       en;
      logic [1:0] idx;
      logic [7:0] data;
   } ppr_wr_t;

endpackage

// ### src/ppr_route_lane.sv
// Default or alternative pin selector for one group of peripheral signals
`timescale 1ns/1ns
module ppr_route_lane
   import ppr_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         alt_sel, // High: use alternative pins
   input  wire logic [W-1:0] p_o,     // Peripheral output value
   input  wire logic [W-1:0] p_oe,    // Peripheral output enable
   input  wire logic [W-1:0] def_i,   // Level at default pins
   input  wire logic [W-1:0] alt_i,   // Level at alternative pins
   output logic      [W-1:0] def_o,   // Drive value, default pins
   output logic      [W-1:0] def_oe,  // Enable, default pins
   output logic      [W-1:0] alt_o,   // Drive value, alternative pins
   output logic      [W-1:0] alt_oe,  // Enable, alternative pins
   output logic      [W-1:0] p_i      // Level returned to the peripheral
);

   always_comb begin
      def_o  = alt_sel ? '0 : p_o;
      def_oe = alt_sel ? '0 : p_oe;
      alt_o  = alt_sel ? p_o : '0;
      alt_oe = alt_sel ? p_oe : '0;
      p_i    = alt_sel ? alt_i : def_i;
   end

endmodule // ppr_route_lane

// ### src/ppr_axil_slave.sv
// AXI4-Lite slave front end for the route registers
`timescale 1ns/1ns
`include "ppr_cfg.svh"
module ppr_axil_slave
   import ppr_pkg::*;
#(
   parameter int AW = `PPR_ADDR_W
) (
   input  wire logic          sys_clk,  // Clock
   input  wire logic          resetn,   // Async reset, low
   input  wire logic [AW-1:0] awaddr,   // Write address
   input  wire logic          awvalid,  // Write address valid
   output logic               awready,  // Write address ready
   input  wire logic [31:0]   wdata,    // Write data
   input  wire logic [3:0]    wstrb,    // Byte strobes
   input  wire logic          wvalid,   // Write data valid
   output logic               wready,   // Write data ready
   output logic [1:0]         bresp,    // Write response
   output logic               bvalid,   // Write response valid
   input  wire logic          bready,   // Write response ready
   input  wire logic [AW-1:0] araddr,   // Read address
   input  wire logic          arvalid,  // Read address valid
   output logic               arready,  // Read address ready
   output logic [31:0]        rdata,    // Read data
   output logic [1:0]         rresp,    // Read response
   output logic               rvalid,   // Read valid
   input  wire logic          rready,   // Read ready
   output ppr_wr_t            wr,       // Register write, one cycle
   output logic [1:0]         rd_idx,   // Register index being read
   input  wire logic [7:0]    rd_data   // Register value at rd_idx
);

   logic          aw_open_r, aw_open_nxt, w_open_r, w_open_nxt, ar_open_r, ar_open_nxt;
   logic [AW-1:0] aw_addr_r, aw_addr_nxt;
   logic [7:0]    w_data_r, w_data_nxt;
   logic          w_be_r, w_be_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0]    bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [7:0]    rdata_r, rdata_nxt;
   logic          do_wr, wr_ok, rd_ok;

   always_comb begin
      do_wr  = !aw_open_r && !w_open_r && !bvalid_r;
      wr_ok  = (aw_addr_r[1:0] == 2'h0)
               && ({2'h0, aw_addr_r[AW-1:2]} < AW'(`PPR_NUM_REGS));
      rd_ok  = (araddr[1:0] == 2'h0)
               && ({2'h0, araddr[AW-1:2]} < AW'(`PPR_NUM_REGS));
      rd_idx = araddr[3:2];
      wr.en   = do_wr && wr_ok && w_be_r;
      wr.idx  = aw_addr_r[3:2];
      wr.data = w_data_r;
      aw_open_nxt = aw_open_r;
      aw_addr_nxt = aw_addr_r;
      w_open_nxt  = w_open_r;
      w_data_nxt  = w_data_r;
      w_be_nxt    = w_be_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      ar_open_nxt = ar_open_r;
      rvalid_nxt  = rvalid_r;
      rresp_nxt   = rresp_r;
      rdata_nxt   = rdata_r;
      if (awvalid && aw_open_r) begin
         aw_open_nxt = 1'b0;
         aw_addr_nxt = awaddr;
      end
      if (wvalid && w_open_r) begin
         w_open_nxt = 1'b0;
         w_data_nxt = wdata[7:0];
         w_be_nxt   = wstrb[0];
      end
      if (bvalid_r && bready) begin
         bvalid_nxt = 1'b0;
      end
      if (do_wr) begin
         aw_open_nxt = 1'b1;
         w_open_nxt  = 1'b1;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = wr_ok ? `PPR_RESP_OKAY : `PPR_RESP_SLVERR;
      end
      if (rvalid_r && rready) begin
         rvalid_nxt  = 1'b0;
         ar_open_nxt = 1'b1;
      end
      if (arvalid && ar_open_r) begin
         ar_open_nxt = 1'b0;
         rvalid_nxt  = 1'b1;
         rdata_nxt   = rd_ok ? rd_data : 8'h00;
         rresp_nxt   = rd_ok ? `PPR_RESP_OKAY : `PPR_RESP_SLVERR;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         aw_open_r <= 1'b1;
         w_open_r  <= 1'b1;
         ar_open_r <= 1'b1;
         aw_addr_r <= '0;
         w_data_r  <= 8'h00;
         w_be_r    <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= `PPR_RESP_OKAY;
         rvalid_r  <= 1'b0;
         rresp_r   <= `PPR_RESP_OKAY;
         rdata_r   <= 8'h00;
      end else begin
         aw_open_r <= aw_open_nxt;
         w_open_r  <= w_open_nxt;
         ar_open_r <= ar_open_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_data_r  <= w_data_nxt;
         w_be_r    <= w_be_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         rvalid_r  <= rvalid_nxt;
         rresp_r   <= rresp_nxt;
         rdata_r   <= rdata_nxt;
      end
   end

   assign awready = aw_open_r;
   assign wready  = w_open_r;
   assign arready = ar_open_r;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;
   assign rvalid  = rvalid_r;
   assign rresp   = rresp_r;
   assign rdata   = {24'h000000, rdata_r};

endmodule // ppr_axil_slave

// ### src/ppr_top.sv
// Peripheral pin router: route registers and pin selectors
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "ppr_cfg.svh"
module ppr_top
   import ppr_pkg::*;
#(
   parameter int AW = `PPR_ADDR_W
) (
   input  wire logic          sys_clk,       // Clock, 100 MHz
   input  wire logic          resetn,        // Async reset, low
   input  wire logic [AW-1:0] awaddr,        // AXI write address
   input  wire logic          awvalid,       // AXI write address valid
   output logic               awready,       // AXI write address ready
   input  wire logic [31:0]   wdata,         // AXI write data
   input  wire logic [3:0]    wstrb,         // AXI byte strobes
   input  wire logic          wvalid,        // AXI write data valid
   output logic               wready,        // AXI write data ready
   output logic [1:0]         bresp,         // AXI write response
   output logic               bvalid,        // AXI write response valid
   input  wire logic          bready,        // AXI write response ready
   input  wire logic [AW-1:0] araddr,        // AXI read address
   input  wire logic          arvalid,       // AXI read address valid
   output logic               arready,       // AXI read address ready
   output logic [31:0]        rdata,         // AXI read data
   output logic [1:0]         rresp,         // AXI read response
   output logic               rvalid,        // AXI read valid
   input  wire logic          rready,        // AXI read ready
   input  wire logic [1:0]    lut_o,         // Logic table outputs
   input  wire logic [2:0]    evt_i,         // Event levels for outputs
   input  wire logic [1:0]    twi_o,         // Two-wire drive values
   input  wire logic [1:0]    twi_oe,        // Two-wire drive enables
   input  wire logic [3:0]    spi_o,         // Serial peripheral drive values
   input  wire logic [3:0]    spi_oe,        // Serial peripheral enables
   input  wire logic [1:0]    usart_o,       // Async serial drive values
   input  wire logic [1:0]    usart_oe,      // Async serial enables
   input  wire logic [5:0]    tca_wave,      // Timer A waveform outputs
   input  wire logic          tca_split,     // Timer A in split mode
   input  wire logic          tcb_o,         // Timer B output
   input  wire logic [1:0]    twi_def_i,     // Two-wire default pin levels
   input  wire logic [1:0]    twi_alt_i,     // Two-wire alternative levels
   input  wire logic [3:0]    spi_def_i,     // Serial peripheral default levels
   input  wire logic [3:0]    spi_alt_i,     // Serial peripheral alternative levels
   input  wire logic [1:0]    usart_def_i,   // Async serial default levels
   input  wire logic [1:0]    usart_alt_i,   // Async serial alternative levels
   output logic [1:0]         twi_i,         // Two-wire levels to peripheral
   output logic [3:0]         spi_i,         // Serial peripheral levels in
   output logic [1:0]         usart_i,       // Async serial levels in
   output logic [1:0]         lut_def_o,     // Logic table default pins
   output logic [1:0]         lut_def_oe,    // Their enables
   output logic [1:0]         lut_alt_o,     // Logic table alternative pins
   output logic [1:0]         lut_alt_oe,    // Their enables
   output logic [2:0]         evout_o,       // Event output pins
   output logic [2:0]         evout_oe,      // Their enables
   output logic [1:0]         twi_def_o,     // Two-wire default drive
   output logic [1:0]         twi_def_oe,    // Its enables
   output logic [1:0]         twi_alt_o,     // Two-wire alternative drive
   output logic [1:0]         twi_alt_oe,    // Its enables
   output logic [3:0]         spi_def_o,     // Serial peripheral default drive
   output logic [3:0]         spi_def_oe,    // Its enables
   output logic [3:0]         spi_alt_o,     // Serial peripheral alternative drive
   output logic [3:0]         spi_alt_oe,    // Its enables
   output logic [1:0]         usart_def_o,   // Async serial default drive
   output logic [1:0]         usart_def_oe,  // Its enables
   output logic [1:0]         usart_alt_o,   // Async serial alternative drive
   output logic [1:0]         usart_alt_oe,  // Its enables
   output logic [5:0]         tca_def_o,     // Timer A default pins
   output logic [5:0]         tca_def_oe,    // Their enables
   output logic [5:0]         tca_alt_o,     // Timer A alternative pins
   output logic [5:0]         tca_alt_oe,    // Their enables
   output logic               tcb_def_o,     // Timer B default pin
   output logic               tcb_def_oe,    // Its enable
   output logic               tcb_alt_o,     // Timer B alternative pin
   output logic               tcb_alt_oe     // Its enable
);

   ppr_regs_t  regs_r, regs_nxt;
   ppr_wr_t    wr;
   logic [1:0] rd_idx;
   logic [7:0] rd_data;
   logic [5:0] tca_sel;

   // Pin side, combinational then registered
   logic [1:0] lut_do, lut_doe, lut_ao, lut_aoe;
   logic [2:0] ev_o_nxt, ev_oe_nxt;
   logic [1:0] twi_do, twi_doe, twi_ao, twi_aoe, twi_pi;
   logic [3:0] spi_do, spi_doe, spi_ao, spi_aoe, spi_pi;
   logic [1:0] us_do, us_doe, us_ao, us_aoe, us_pi;
   logic [5:0] tca_do, tca_doe, tca_ao, tca_aoe;
   logic       tcb_do, tcb_doe, tcb_ao, tcb_aoe;

   ppr_axil_slave #(
      .AW (AW)
   ) u_bus (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wr      (wr),
      .rd_idx  (rd_idx),
      .rd_data (rd_data)
   );

   // Register file; only assigned bits are stored
   always_comb begin
      regs_nxt = regs_r;
      if (wr.en) begin
         case (wr.idx)
            `PPR_IDX_LOGIC_EV: regs_nxt.logic_event_route = wr.data & `PPR_MASK_LOGIC_EV;
            `PPR_IDX_COMM:     regs_nxt.comm_pin_route    = wr.data & `PPR_MASK_COMM;
            `PPR_IDX_TIMER_A:  regs_nxt.timer_a_pin_route = wr.data & `PPR_MASK_TIMER_A;
            `PPR_IDX_TIMER_B:  regs_nxt.timer_b_pin_route = wr.data & `PPR_MASK_TIMER_B;
            default:           regs_nxt = regs_r;
         endcase
      end
      case (rd_idx)
         `PPR_IDX_LOGIC_EV: rd_data = regs_r.logic_event_route;
         `PPR_IDX_COMM:     rd_data = regs_r.comm_pin_route;
         `PPR_IDX_TIMER_A:  rd_data = regs_r.timer_a_pin_route;
         `PPR_IDX_TIMER_B:  rd_data = regs_r.timer_b_pin_route;
         default:           rd_data = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         regs_r <= {4{`PPR_RST_ROUTE}};
      end else begin
         regs_r <= regs_nxt;
      end
   end

   // Logic table outputs
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_lut
         ppr_route_lane #(.W(1)) u_lut (
            .alt_sel (regs_r.logic_event_route[`PPR_B_LOGIC_TABLE_ZERO_ALT_PIN + gi]),
            .p_o     (lut_o[gi]),
            .p_oe    (1'b1),
            .def_i   (1'b0),
            .alt_i   (1'b0),
            .def_o   (lut_do[gi]),
            .def_oe  (lut_doe[gi]),
            .alt_o   (lut_ao[gi]),
            .alt_oe  (lut_aoe[gi]),
            .p_i     ()
         );
      end
      // Timer A: upper three lanes only move in split mode
      for (gi = 0; gi < 6; gi++) begin : g_tca
         assign tca_sel[gi] = (gi < `PPR_B_WAVE_SPLIT)
                              ? regs_r.timer_a_pin_route[gi]
                              : regs_r.timer_a_pin_route[gi] & tca_split;
         ppr_route_lane #(.W(1)) u_tca (
            .alt_sel (tca_sel[gi]),
            .p_o     (tca_wave[gi]),
            .p_oe    (1'b1),
            .def_i   (1'b0),
            .alt_i   (1'b0),
            .def_o   (tca_do[gi]),
            .def_oe  (tca_doe[gi]),
            .alt_o   (tca_ao[gi]),
            .alt_oe  (tca_aoe[gi]),
            .p_i     ()
         );
      end
   endgenerate

   ppr_route_lane #(.W(2)) u_twi (
      .alt_sel (regs_r.comm_pin_route[`PPR_B_TWO_WIRE]),
      .p_o     (twi_o),
      .p_oe    (twi_oe),
      .def_i   (twi_def_i),
      .alt_i   (twi_alt_i),
      .def_o   (twi_do),
      .def_oe  (twi_doe),
      .alt_o   (twi_ao),
      .alt_oe  (twi_aoe),
      .p_i     (twi_pi)
   );

   ppr_route_lane #(.W(4)) u_spi (
      .alt_sel (regs_r.comm_pin_route[`PPR_B_SERIAL_PER]),
      .p_o     (spi_o),
      .p_oe    (spi_oe),
      .def_i   (spi_def_i),
      .alt_i   (spi_alt_i),
      .def_o   (spi_do),
      .def_oe  (spi_doe),
      .alt_o   (spi_ao),
      .alt_oe  (spi_aoe),
      .p_i     (spi_pi)
   );

   ppr_route_lane #(.W(2)) u_usart (
      .alt_sel (regs_r.comm_pin_route[`PPR_B_ASYNC_SER]),
      .p_o     (usart_o),
      .p_oe    (usart_oe),
      .def_i   (usart_def_i),
      .alt_i   (usart_alt_i),
      .def_o   (us_do),
      .def_oe  (us_doe),
      .alt_o   (us_ao),
      .alt_oe  (us_aoe),
      .p_i     (us_pi)
   );

   ppr_route_lane #(.W(1)) u_tcb (
      .alt_sel (regs_r.timer_b_pin_route[`PPR_B_TIMER_B]),
      .p_o     (tcb_o),
      .p_oe    (1'b1),
      .def_i   (1'b0),
      .alt_i   (1'b0),
      .def_o   (tcb_do),
      .def_oe  (tcb_doe),
      .alt_o   (tcb_ao),
      .alt_oe  (tcb_aoe),
      .p_i     ()
   );

   // Event outputs drive only while enabled
   always_comb begin
      ev_oe_nxt = regs_r.logic_event_route[`PPR_B_EVENT_OUT_TWO_ENABLE:`PPR_B_EVENT_OUT_ZERO_ENABLE];
      ev_o_nxt  = evt_i & ev_oe_nxt;
   end

   // All pin outputs leave from flops; one cycle behind the register
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         {lut_def_o, lut_def_oe, lut_alt_o, lut_alt_oe}     <= '0;
         {evout_o, evout_oe}                                <= '0;
         {twi_def_o, twi_def_oe, twi_alt_o, twi_alt_oe}     <= '0;
         {spi_def_o, spi_def_oe, spi_alt_o, spi_alt_oe}     <= '0;
         {usart_def_o, usart_def_oe, usart_alt_o, usart_alt_oe} <= '0;
         {tca_def_o, tca_def_oe, tca_alt_o, tca_alt_oe}     <= '0;
         {tcb_def_o, tcb_def_oe, tcb_alt_o, tcb_alt_oe}     <= '0;
         {twi_i, spi_i, usart_i}                            <= '0;
      end else begin
         {lut_def_o, lut_def_oe, lut_alt_o, lut_alt_oe}     <= {lut_do, lut_doe, lut_ao, lut_aoe};
         {evout_o, evout_oe}                                <= {ev_o_nxt, ev_oe_nxt};
         {twi_def_o, twi_def_oe, twi_alt_o, twi_alt_oe}     <= {twi_do, twi_doe, twi_ao, twi_aoe};
         {spi_def_o, spi_def_oe, spi_alt_o, spi_alt_oe}     <= {spi_do, spi_doe, spi_ao, spi_aoe};
         {usart_def_o, usart_def_oe, usart_alt_o, usart_alt_oe} <= {us_do, us_doe, us_ao, us_aoe};
         {tca_def_o, tca_def_oe, tca_alt_o, tca_alt_oe}     <= {tca_do, tca_doe, tca_ao, tca_aoe};
         {tcb_def_o, tcb_def_oe, tcb_alt_o, tcb_alt_oe}     <= {tcb_do, tcb_doe, tcb_ao, tcb_aoe};
         {twi_i, spi_i, usart_i}                            <= {twi_pi, spi_pi, us_pi};
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   reg_write_a: assert property (
      wr.en && wr.idx == `PPR_IDX_TIMER_B |=>
      regs_r.timer_b_pin_route == ($past(wr.data) & `PPR_MASK_TIMER_B))
      else $error("route register write not stored");
   lut_one_alt_a: assert property (
      regs_r.logic_event_route[`PPR_B_LOGIC_TABLE_ONE_ALT_PIN] |=>
      lut_alt_o[1] == $past(lut_o[1]) && lut_alt_oe[1] && !lut_def_oe[1])
      else $error("logic table 1 not on alternative pin");
   lut_zero_def_a: assert property (
      !regs_r.logic_event_route[`PPR_B_LOGIC_TABLE_ZERO_ALT_PIN] |=>
      lut_def_o[0] == $past(lut_o[0]) && lut_def_oe[0] && !lut_alt_oe[0])
      else $error("logic table 0 not on default pin");
   event_gate_a: assert property (
      ##1 evout_oe == $past(regs_r.logic_event_route[`PPR_B_EVENT_OUT_TWO_ENABLE:`PPR_B_EVENT_OUT_ZERO_ENABLE])
      && (evout_o & ~evout_oe) == 3'h0)
      else $error("event output drive does not follow its enable");
   two_wire_alt_a: assert property (
      regs_r.comm_pin_route[`PPR_B_TWO_WIRE] |=>
      twi_alt_oe == $past(twi_oe) && twi_def_oe == 2'h0 && twi_i == $past(twi_alt_i))
      else $error("two-wire signals not moved");
   serial_per_alt_a: assert property (
      regs_r.comm_pin_route[`PPR_B_SERIAL_PER] |=>
      spi_alt_o == $past(spi_o) && spi_alt_oe == $past(spi_oe) && spi_def_oe == 4'h0)
      else $error("serial peripheral signals not moved");
   async_ser_def_a: assert property (
      !regs_r.comm_pin_route[`PPR_B_ASYNC_SER] |=>
      usart_def_oe == $past(usart_oe) && usart_alt_oe == 2'h0 && usart_i == $past(usart_def_i))
      else $error("async serial signals not on default pins");
   wave_normal_a: assert property (
      !tca_split |=> tca_alt_oe[5:3] == 3'h0 && tca_def_oe[5:3] == 3'h7)
      else $error("upper timer A waveforms moved in normal mode");
   wave_low_alt_a: assert property (
      regs_r.timer_a_pin_route[0] |=> tca_alt_o[0] == $past(tca_wave[0]) && !tca_def_oe[0])
      else $error("timer A waveform 0 not on alternative pin");
   timer_b_alt_a: assert property (
      regs_r.timer_b_pin_route[`PPR_B_TIMER_B] |=> tcb_alt_o == $past(tcb_o) && !tcb_def_oe)
      else $error("timer B output not on alternative pin");
   unassigned_zero_a: assert property (
      (regs_r.logic_event_route & ~`PPR_MASK_LOGIC_EV) == 8'h00
      && (regs_r.comm_pin_route & ~`PPR_MASK_COMM) == 8'h00
      && (regs_r.timer_a_pin_route & ~`PPR_MASK_TIMER_A) == 8'h00
      && (regs_r.timer_b_pin_route & ~`PPR_MASK_TIMER_B) == 8'h00)
      else $error("unassigned route bit is set");

endmodule // ppr_top

// ### dv/tb_ppr_top.sv
// Self-checking testbench of the peripheral pin router
`timescale 1ns/1ns
module tb_ppr_top;
   import ppr_pkg::*;
   logic sys_clk = 1'h0, resetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
   logic bready = 1'h0, rready = 1'h0, tca_split = 1'h0, tcb_o = 1'h1;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf, spi_o = 4'h9, spi_oe = 4'h6;
   logic [3:0] spi_def_i = 4'h3, spi_alt_i = 4'hc;
   logic [1:0] lut_o = 2'h2, twi_o = 2'h1, twi_oe = 2'h3, usart_o = 2'h2, usart_oe = 2'h1;
   logic [1:0] twi_def_i = 2'h1, twi_alt_i = 2'h2, usart_def_i = 2'h1, usart_alt_i = 2'h2;
   logic [2:0] evt_i = 3'h5;
   logic [5:0] tca_wave = 6'h2b;
   logic [31:0] wdata = 32'h0, rdata;
   logic awready, wready, bvalid, arready, rvalid, tcb_def_o, tcb_def_oe, tcb_alt_o, tcb_alt_oe;
   logic [1:0] bresp, rresp, twi_i, usart_i, lut_def_o, lut_def_oe, lut_alt_o, lut_alt_oe;
   logic [1:0] twi_def_o, twi_def_oe, twi_alt_o, twi_alt_oe;
   logic [1:0] usart_def_o, usart_def_oe, usart_alt_o, usart_alt_oe;
   logic [3:0] spi_i, spi_def_o, spi_def_oe, spi_alt_o, spi_alt_oe;
   logic [5:0] tca_def_o, tca_def_oe, tca_alt_o, tca_alt_oe;
   logic [2:0] evout_o, evout_oe;
   int error_cnt = 0, samples_checked = 0;
   ppr_top i_dut (.sys_clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .lut_o, .evt_i, .twi_o, .twi_oe, .spi_o, .spi_oe, .usart_o, .usart_oe,
      .tca_wave, .tca_split, .tcb_o, .twi_def_i, .twi_alt_i, .spi_def_i, .spi_alt_i,
      .usart_def_i, .usart_alt_i, .twi_i, .spi_i, .usart_i, .lut_def_o, .lut_def_oe,
      .lut_alt_o, .lut_alt_oe, .evout_o, .evout_oe, .twi_def_o, .twi_def_oe, .twi_alt_o,
      .twi_alt_oe, .spi_def_o, .spi_def_oe, .spi_alt_o, .spi_alt_oe, .usart_def_o,
      .usart_def_oe, .usart_alt_o, .usart_alt_oe, .tca_def_o, .tca_def_oe, .tca_alt_o,
      .tca_alt_oe, .tcb_def_o, .tcb_def_oe, .tcb_alt_o, .tcb_alt_oe);
   always #5 sys_clk = ~sys_clk;
   task automatic chk(string n, logic [63:0] got, logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] d, output logic [1:0] r);
      logic fa = 1'h0, fw = 1'h0;
      @(posedge sys_clk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, 24'h0, d, 3'h7};
      while (!(fa && fw)) begin
         @(posedge sys_clk);
         fa = fa || awready;
         fw = fw || wready;
         {awvalid, wvalid} <= {!fa, !fw};
      end
      do @(posedge sys_clk); while (!bvalid);
      r = bresp;
      bready <= 1'h0;
   endtask
   task automatic rd(logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      {araddr, arvalid, rready} <= {a, 2'h3};
      do @(posedge sys_clk); while (!arready);
      arvalid <= 1'h0;
      do @(posedge sys_clk); while (!rvalid);
      {d, r} = {rdata, rresp};
      rready <= 1'h0;
   endtask
   task automatic grp(string n, logic [5:0] s, v, oe, d, de, a, ae);
      chk(n, {d, de, a, ae}, {v & ~s, oe & ~s, v & s, oe & s});
   endtask
   // Pins settle one edge after the last input or register change; the task waits two edges
   task automatic pins(logic [7:0] a, b, c, t);
      repeat (2) @(posedge sys_clk);
      #1;
      grp("lut", a[5:4], lut_o, 6'h3, lut_def_o, lut_def_oe, lut_alt_o, lut_alt_oe);
      chk("evout", {evout_oe, evout_o}, {a[2:0], evt_i & a[2:0]});
      grp("twi", {6{b[4]}}, twi_o, twi_oe, twi_def_o, twi_def_oe, twi_alt_o, twi_alt_oe);
      grp("spi", {6{b[2]}}, spi_o, spi_oe, spi_def_o, spi_def_oe, spi_alt_o, spi_alt_oe);
      grp("usart", {6{b[0]}}, usart_o, usart_oe, usart_def_o, usart_def_oe, usart_alt_o,
          usart_alt_oe);
      chk("pin_in", {twi_i, spi_i, usart_i}, {b[4] ? twi_alt_i : twi_def_i,
          b[2] ? spi_alt_i : spi_def_i, b[0] ? usart_alt_i : usart_def_i});
      grp("tca", {c[5:3] & {3{tca_split}}, c[2:0]}, tca_wave, 6'h3f, tca_def_o, tca_def_oe,
          tca_alt_o, tca_alt_oe);
      grp("tcb", t[0], tcb_o, 6'h1, tcb_def_o, tcb_def_oe, tcb_alt_o, tcb_alt_oe);
   endtask
   task automatic t_regs;
      logic [7:0] m [4] = '{8'h37, 8'h15, 8'h3f, 8'h01};
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 4; i++) begin
         rd(4'(4 * i), d, r);
         chk("reset value", d, 32'h0);
         wr(4'(4 * i), 8'hff, r);
         rd(4'(4 * i), d, r);
         chk("readback", {r, d}, {2'h0, 24'h0, m[i]});
      end
      wr(4'h1, 8'h00, r);
      chk("unmapped bresp", r, 2'h2);
      rd(4'h6, d, r);
      chk("unmapped read", {r, d}, {2'h2, 32'h0});
      wstrb <= 4'he;
      wr(4'h0, 8'h00, r);
      chk("strobe off bresp", r, 2'h0);
      rd(4'h0, d, r);
      chk("strobe off data", d, 32'h37);
      wstrb <= 4'hf;
      $display("test registers done");
   endtask
   task automatic t_route;
      logic [7:0] v [4] = '{8'h21, 8'h11, 8'h2a, 8'h00};
      logic [1:0] r;
      pins(8'h37, 8'h15, 8'h3f, 8'h01);
      @(posedge sys_clk);
      {lut_o, evt_i, twi_o, twi_oe, spi_o, spi_oe, usart_o, usart_oe, tca_wave, tcb_o} <=
         ~{lut_o, evt_i, twi_o, twi_oe, spi_o, spi_oe, usart_o, usart_oe, tca_wave, tcb_o};
      {twi_def_i, spi_def_i, usart_def_i} <= ~{twi_def_i, spi_def_i, usart_def_i};
      tca_split <= 1'h1;
      pins(8'h37, 8'h15, 8'h3f, 8'h01);
      for (int i = 0; i < 4; i++) wr(4'(4 * i), v[i], r);
      pins(v[0], v[1], v[2], v[3]);
      $display("test routing done");
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      resetn <= 1'h1;
      pins(8'h0, 8'h0, 8'h0, 8'h0);
      t_regs();
      t_route();
      final_report();
   end
   initial begin
      repeat (3000) @(posedge sys_clk);
      error_cnt++;
      final_report();
   end
endmodule // tb_ppr_top
